/* File: oss_defines.svh */
/*
  Constants of the octal switch serial control block: frame width,
  channel counts, bit positions and reset values.
  Assumes inclusion by bare name from the package; the design file uses the macros without its own include.
*/
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH

// Frame and channel geometry
`define OSS_NCH          8
`define OSS_NPAR         4
`define OSS_MSB          7
// Reset values
`define OSS_CMD_RST      8'h00
`define OSS_SHIFT_RST    8'h00
`define OSS_CNT_RST      4'h0
// Bit count of one full frame
`define OSS_FRAME_BITS   4'h8

`endif

/* File: oss_pkg.sv */
/*
  Types of the octal switch serial control block.
  Assumes oss_defines.svh is on the include path.
*/
`include "oss_defines.svh"

package oss_pkg;

  // Serial pins as driven, synchronised later inside oss_ctrl
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } oss_spi_t;

  // Whole state of the block
  typedef struct packed {
    logic [2:0] sclk_sync;  // Two sync stages plus edge history
    logic [2:0] cs_sync;
    logic [1:0] sdi_sync;
    logic [7:0] shift;      // Eight bit shift register
    logic [7:0] cmd;        // Output latches
    logic [7:0] diag;       // Latched fault bits
    logic [3:0] cnt;        // Falling edges seen this frame, saturating at eight
    logic       sdo;        // Serial output bit
    logic       sdo_oe;     // Serial output enable
  } oss_state_t;

endpackage : oss_pkg

/* File: oss_ctrl.sv */
/*
  Serial control and fault readback of an eight channel low side
  switch: serial shift register, output latches, parallel drive OR,
  fault latching and summary fault flag.
  Assumes the serial pins come from another clock domain and are
  synchronised here; fault inputs come from analog protection on
  clk_sys_i.
*/
`timescale 1ns/100ps

module oss_ctrl
  import oss_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  // Serial pins from the master
  input  wire oss_pkg::oss_spi_t spi_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  // Reset pin, active low, pulled up outside
  input  wire logic       rst_pin_n_i,
  // Parallel drive inputs, pulled down outside
  input  wire logic [3:0] parallel_drive_i,
  // Per channel protection status from analog side
  input  wire logic [7:0] overload_i,
  input  wire logic [7:0] overtemp_i,
  input  wire logic [7:0] open_load_i,
  // Power stage gate commands
  output logic [7:0]      power_output_o,
  // Open drain summary fault, drives low while enabled
  output logic            fault_n_o,
  output logic            fault_n_oe_o
);
  import oss_pkg::*;

  oss_state_t s_q;       // Registered state
  oss_state_t s_d;       // Next state
  logic       sclk_rise; // Serial clock rising, synchronised
  logic       sclk_fall; // Serial clock falling, synchronised
  logic       cs_rise;   // Select release
  logic       cs_fall;   // Select assertion
  logic       cs_low;    // Frame in progress
  logic [7:0] fault_now; // Live per channel faults
  logic [7:0] drive;     // Combined channel drive
  logic [7:0] diag_live; // Diagnosis bits as reported

  // Edge detection reads only second and third stages
  assign sclk_rise = s_q.sclk_sync[1] & ~s_q.sclk_sync[2];
  assign sclk_fall = ~s_q.sclk_sync[1] & s_q.sclk_sync[2];
  assign cs_rise   = s_q.cs_sync[1] & ~s_q.cs_sync[2];
  assign cs_fall   = ~s_q.cs_sync[1] & s_q.cs_sync[2];
  assign cs_low    = ~s_q.cs_sync[2];

  // Per channel faults, each channel on its own
  // Overtemperature counts as a plain fault; thermal cycling stays analog
  assign fault_now = overload_i | overtemp_i | open_load_i;

  // Channel drive, generated per channel
  genvar g;
  generate
    for (g = 0; g < `OSS_NCH; g++)
    begin : g_ch
      if (g < `OSS_NPAR)
      begin : g_par
        // Parallel OR serial; pull-down makes open pin low
        assign drive[g] = s_q.cmd[g] | parallel_drive_i[g];
        // Serial bit overrides parallel for diagnosis
        assign diag_live[g] = s_q.cmd[g] ? ~s_q.diag[g]
                                         : s_q.diag[g];
      end
      else
      begin : g_ser
        assign drive[g] = s_q.cmd[g];
        assign diag_live[g] = s_q.cmd[g] ^ s_q.diag[g];
      end
    end
  endgenerate

  // Next state
  always_comb
  begin
    s_d = s_q;
    // Synchronisers: first stage read only by the second
    s_d.sclk_sync = {s_q.sclk_sync[1:0], spi_i.sclk};
    s_d.cs_sync   = {s_q.cs_sync[1:0], spi_i.cs_n};
    s_d.sdi_sync  = {s_q.sdi_sync[0], spi_i.sdi};
    // Fault latching; new fault wins over clear
    if (cs_rise)
      s_d.diag = fault_now;
    else
      s_d.diag = s_q.diag | fault_now;
    if (!rst_pin_n_i)
    begin
      // Reset pin clears shifter and latches
      s_d.shift  = `OSS_SHIFT_RST;
      s_d.cmd    = `OSS_CMD_RST;
      s_d.cnt    = `OSS_CNT_RST;
      s_d.sdo    = 1'b0;
      s_d.sdo_oe = 1'b0;
    end
    else if (cs_fall)
    begin
      // Load reported fault bits, drive first bit
      s_d.shift  = diag_live;
      s_d.sdo    = diag_live[`OSS_MSB];
      s_d.sdo_oe = 1'b1;
      s_d.cnt    = `OSS_CNT_RST;
    end
    else if (cs_rise)
    begin
      // Apply only when a complete frame was clocked
      if (s_q.cnt == `OSS_FRAME_BITS)
        s_d.cmd = s_q.shift;
      s_d.sdo_oe = 1'b0;
    end
    else if (cs_low)
    begin
      // Shift in MSB first; top bit falls out for chaining
      if (sclk_fall)
      begin
        s_d.shift = {s_q.shift[6:0], s_q.sdi_sync[1]};
        if (s_q.cnt != `OSS_FRAME_BITS)
          s_d.cnt = s_q.cnt + 4'h1;
      end
      // Next bit presented after rising edge; the top bit already
      // stands from select fall, and the rise precedes that bit's shift
      if (sclk_rise)
        s_d.sdo = s_q.shift[`OSS_MSB - 1];
    end
    // Deselected: clock and data ignored
  end

  // State register
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      s_q           <= '0;
      s_q.cs_sync   <= 3'h7;
      s_q.cmd       <= `OSS_CMD_RST;
    end
    else
      s_q <= s_d;
  end

  // Outputs; common reset path forces all channels off
  assign power_output_o = rst_pin_n_i ? drive : 8'h00;
  assign sdo_o          = s_q.sdo;
  assign sdo_oe_o       = s_q.sdo_oe & cs_low;
  assign fault_n_o      = 1'b0;
  assign fault_n_oe_o   = |s_q.diag;

endmodule : oss_ctrl

/* File: oss_master.sv */
/* Serial master model for oss_ctrl: frames of n bits, MSB first.
   Assumes the bench calls xfer and feeds back the serial output. */
`timescale 1ns/100ps
module oss_master (
  // Serial pins
  output oss_pkg::oss_spi_t spi_o,
  input  wire logic         sdo_i
);
  initial spi_o = 3'b010;  // Idle: select high, clock low
  // Clock runs only inside frames, 200 ns period
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    spi_o.cs_n = 1'b0;
    #300;
    for (int i = n - 1; i >= 0; i--)
    begin
      #50 spi_o.sdi = tx[i];
      #50 rx[i] = sdo_i;
      spi_o.sclk = 1'b1;
      #100 spi_o.sclk = 1'b0;
    end
    #300 spi_o.cs_n = 1'b1;
    spi_o.sdi = ~spi_o.sdi;  // Released line shows no stale value
    #400;
  endtask : xfer
endmodule : oss_master

/* File: oss_ctrl_chk.sv */
/* Port assertions of oss_ctrl, bound to it below.
   Assumes srst_i is synchronous on clk_sys_i. */
`timescale 1ns/100ps
module oss_ctrl_chk
  import oss_pkg::*;
(
  // Clock, reset, inputs and power outputs
  input wire logic clk_sys_i, srst_i, rst_pin_n_i,
  input wire oss_pkg::oss_spi_t spi_i,
  input wire logic [3:0] parallel_drive_i,
  input wire logic [7:0] overload_i, overtemp_i, open_load_i, power_output_o,
  // Outputs
  input wire logic sdo_oe_o, fault_n_o, fault_n_oe_o
);
  logic [3:0] hi_q;  // Cycles with select high, saturating
  always_ff @(posedge clk_sys_i)
    hi_q <= (srst_i || !spi_i.cs_n) ? 4'h0 : hi_q + {3'h0, hi_q != 4'hF};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence sel_low_s; (!spi_i.cs_n && rst_pin_n_i) [*6]; endsequence
  pin_off_a: assert property (!rst_pin_n_i |-> power_output_o == 8'h00)
    else $error("outputs on with reset pin low");
  par_or_a: assert property (rst_pin_n_i |-> &(power_output_o[3:0] | ~parallel_drive_i))
    else $error("parallel drive not ORed");
  idle_hold_a: assert property (hi_q > 4'h6 && rst_pin_n_i && $past(rst_pin_n_i)
    && !$past(srst_i) |-> $stable(power_output_o[7:4]))
    else $error("serial channels changed while idle");
  sdo_off_a: assert property (hi_q > 4'h6 |-> !sdo_oe_o)
    else $error("serial output driven while idle");
  sdo_on_a: assert property (sel_low_s |-> sdo_oe_o)
    else $error("serial output not driven in frame");
  flag_set_a: assert property (|{overload_i, overtemp_i, open_load_i} |-> ##[0:3] fault_n_oe_o)
    else $error("fault flag late");
  flag_low_a: assert property (fault_n_oe_o |-> !fault_n_o)
    else $error("fault pin not low");
  fault_hold_a: assert property (fault_n_oe_o && hi_q > 4'h8 && rst_pin_n_i |=> fault_n_oe_o)
    else $error("latched fault lost");
endmodule : oss_ctrl_chk
bind oss_ctrl oss_ctrl_chk oss_ctrl_chk_i (.clk_sys_i, .srst_i, .rst_pin_n_i, .spi_i,
  .parallel_drive_i, .overload_i, .overtemp_i, .open_load_i, .power_output_o,
  .sdo_oe_o, .fault_n_o, .fault_n_oe_o);

/* File: oss_ctrl_tb.sv */
/* Self-checking bench of oss_ctrl against a latch model.
   Assumes oss_master and the checker are compiled first. */
`timescale 1ns/100ps
module oss_ctrl_tb;
  import oss_pkg::*;
  logic        clk_sys_i = 1'b0, srst_i = 1'b1, rst_n = 1'b1, sdo, sdo_oe, flt, flt_oe;
  logic [3:0]  par = 4'h0;
  logic [7:0]  ovl = 8'h00, pwr, cmd_m = 8'h00;  // cmd_m: model of the latches
  logic [15:0] rx;
  logic [31:0] seed = 32'hD123;
  oss_spi_t    spi;
  int          failures = 0, checks = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  oss_master oss_master_i (.spi_o(spi), .sdo_i(sdo_oe ? sdo : ~sdo));
  oss_ctrl oss_ctrl_i (.clk_sys_i, .srst_i, .spi_i(spi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .rst_pin_n_i(rst_n), .parallel_drive_i(par), .overload_i(ovl), .overtemp_i(8'h00),
    .open_load_i(8'h00), .power_output_o(pwr), .fault_n_o(flt), .fault_n_oe_o(flt_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One frame, then let the update land
  task automatic frame(input logic [15:0] tx, input int n);
    oss_master_i.xfer(tx, n, rx);
    @(posedge clk_sys_i) #1;
  endtask : frame
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1 srst_i = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      par = seed[11:8];
      frame({8'h00, seed[7:0]}, 8);
      chk("readback", {8'h00, cmd_m}, rx);
      cmd_m = seed[7:0];
      chk("outputs", {cmd_m[7:4], cmd_m[3:0] | par}, pwr);
    end
    par = 4'h0;
    frame(16'h00A5, 4);
    chk("short frame", cmd_m, pwr);
    frame(16'h3CC3, 16);
    chk("chain", {cmd_m, 8'h3C}, rx);
    cmd_m = 8'hC3;
    chk("chain out", cmd_m, pwr);
    $display("serial tests done");
    #1 ovl = 8'h04;
    repeat (3) @(posedge clk_sys_i);
    #1 ovl = 8'h00;
    repeat (3) @(posedge clk_sys_i);
    chk("flag", 16'h0001, flt_oe);
    frame({8'h00, cmd_m}, 8);
    chk("fault bits", cmd_m ^ 8'h04, rx);
    chk("flag clear", 16'h0000, flt_oe);
    frame({8'h00, cmd_m}, 8);
    chk("clean bits", cmd_m, rx);
    $display("fault tests done");
    rst_n = 1'b0;
    #1 chk("pin reset", 16'h0000, pwr);
    @(posedge clk_sys_i) #1 rst_n = 1'b1;
    #1 chk("after reset", 16'h0000, pwr);
    $display("reset test done");
    end_sim();
  end
  initial
  begin
    #2000000 failures++;
    end_sim();
  end
endmodule : oss_ctrl_tb
